/* File: bench/asd_decoder_assertions.sv */
// Concurrent checks on the alternate space decoder ports
`default_nettype none
module asd_decoder_chk (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        req_valid,
  input wire logic        req_store,
  input wire logic        req_priv,
  input wire logic        req_iside,
  input wire logic [1:0]  req_size,
  input wire logic [7:0]  space_identifier,
  input wire logic [31:0] virtual_addr,
  input wire logic        rsp_valid,
  input wire logic        access_error,
  input wire logic        mmu_claim,
  input wire logic        tc_flush_i,
  input wire logic        tc_flush_d,
  input wire logic        tc_probe_i,
  input wire logic        tc_probe_d,
  input wire logic [3:0]  tc_op_kind,
  input wire logic        mmu_reg_rd_i,
  input wire logic        mmu_reg_rd_d,
  input wire logic [3:0]  mmu_reg_sel,
  input wire logic        line_flush_i,
  input wire logic        line_flush_d,
  input wire logic [2:0]  line_flush_kind,
  input wire logic        passthru,
  input wire logic        rm_update_en,
  input wire logic [35:0] physical_addr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Privileged request and space shorthands
  wire logic       pv = req_valid && req_priv;
  wire logic [7:0] sid = space_identifier;
  wire logic       rsv = sid inside {8'h00, 8'h15, 8'h16, 8'h1d, 8'h1e} ||
                         sid[7];
  wire logic       in_mmu = sid inside {[8'h03:8'h0b], [8'h20:8'h2f]};
  rsp_follow_a: assert property (req_valid |=> rsp_valid)
    else $error("no answer one cycle after a request");
  reserved_err_a: assert property (req_valid && rsv |=> access_error)
    else $error("reserved space not flagged");
  mmu_claim_a: assert property (pv && in_mmu |=> mmu_claim)
    else $error("mmu did not claim its space");
  flush_both_a: assert property (pv && sid == 8'h03 && req_store |=>
    tc_flush_i && tc_flush_d && !tc_probe_i && !tc_probe_d)
    else $error("flush not sent to both caches");
  probe_route_a: assert property (pv && sid == 8'h03 && !req_store |=>
    tc_probe_i == $past(req_iside) && tc_probe_d != $past(req_iside))
    else $error("probe answered by wrong cache");
  op_kind_a: assert property (pv && sid == 8'h03 |=>
    tc_op_kind == $past(virtual_addr[11:8]))
    else $error("flush or probe kind wrong");
  reg_size_a: assert property (req_valid && sid == 8'h04 && req_size != 2'h2
    |=> access_error && !mmu_reg_rd_i && !mmu_reg_rd_d)
    else $error("non-word register access not flagged");
  reg_sel_a: assert property (pv && sid == 8'h04 |=>
    mmu_reg_sel == $past(virtual_addr[11:8]))
    else $error("register select wrong");
  iline_only_a: assert property (pv && sid inside {[8'h18:8'h1c]} |=>
    line_flush_i && !line_flush_d && line_flush_kind == $past(sid[2:0]))
    else $error("instruction line flush misrouted");
  pass_addr_a: assert property (pv && sid[7:4] == 4'h2 |=>
    passthru && !rm_update_en &&
    physical_addr == {$past(sid[3:0]), $past(virtual_addr)})
    else $error("pass-through address or update wrong");
  // Main scenarios reached
  flush_c: cover property (tc_flush_d);
  probe_c: cover property (tc_probe_i);
  pass_c: cover property (passthru);
endmodule
bind asd_decoder asd_decoder_chk u_asd_decoder_chk (
  .core_clk(core_clk), .nrst(nrst), .req_valid(req_valid),
  .req_store(req_store), .req_priv(req_priv), .req_iside(req_iside),
  .req_size(req_size), .space_identifier(space_identifier),
  .virtual_addr(virtual_addr), .rsp_valid(rsp_valid),
  .access_error(access_error), .mmu_claim(mmu_claim),
  .tc_flush_i(tc_flush_i), .tc_flush_d(tc_flush_d),
  .tc_probe_i(tc_probe_i), .tc_probe_d(tc_probe_d),
  .tc_op_kind(tc_op_kind), .mmu_reg_rd_i(mmu_reg_rd_i),
  .mmu_reg_rd_d(mmu_reg_rd_d), .mmu_reg_sel(mmu_reg_sel),
  .line_flush_i(line_flush_i), .line_flush_d(line_flush_d),
  .line_flush_kind(line_flush_kind), .passthru(passthru),
  .rm_update_en(rm_update_en), .physical_addr(physical_addr));
`default_nettype wire

/* File: bench/asd_ipu_model.sv */
// Processor-side model that issues alternate accesses to the decoder
`default_nettype none
module asd_ipu_model (
  input  wire logic        core_clk,
  output logic             req_valid,
  output logic             req_store,
  output logic             req_priv,
  output logic             req_iside,
  output logic [1:0]       req_size,
  output logic [7:0]       space_identifier,
  output logic [31:0]      virtual_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet lines at time zero
  initial begin
    {req_valid, req_store, req_priv, req_iside, req_size} = 6'h00;
    {space_identifier, virtual_addr} = 40'h0;
  end
  // One operation per call, so one flush or probe per store/load
  // Privilege comes from the caller; unprivileged only when commanded
  task automatic issue(input logic [7:0] s, input logic [31:0] a,
                       input logic st, pv, isd, input logic [1:0] sz);
    @(posedge core_clk);
    #1;
    {req_valid, req_store, req_priv, req_iside, req_size} =
      {1'b1, st, pv, isd, sz};
    {space_identifier, virtual_addr} = {s, a};
  endtask
  // Released lines flip so a stale value never passes for a live one
  task automatic idle();
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
    {space_identifier, virtual_addr} = ~{space_identifier, virtual_addr};
  endtask
endmodule
`default_nettype wire

/* File: bench/test_alternate_space_decoder.sv */
// Self-checking bench for the alternate space decoder
`default_nettype none
module test_alternate_space_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, nrst, req_valid, req_store, req_priv, req_iside;
  logic [1:0] req_size, mem_space;
  logic [7:0] space_identifier;
  logic [31:0] virtual_addr;
  logic rsp_valid, access_error, mmu_claim, tc_flush_i, tc_flush_d;
  logic tc_probe_i, tc_probe_d, mmu_reg_rd_i, mmu_reg_rd_d, mmu_reg_wr_i;
  logic mmu_reg_wr_d, line_flush_i, line_flush_d, block_copy, block_fill;
  logic passthru, rm_update_en, sysreg_acc, unasg_acc, mem_access, acc_store;
  logic [3:0] tc_op_kind, mmu_reg_sel, cache_acc;
  logic [2:0] tc_diag, line_flush_kind;
  logic [35:0] physical_addr;
  int err_total, compares;
  logic p_v, p_st, p_pv, p_isd;
  logic [1:0] p_sz;
  logic [7:0] p_sid;
  logic [31:0] p_adr;
  // All pulse outputs in one vector, answer flag on top
  wire logic [26:0] obs = {rsp_valid, access_error, mmu_claim, tc_flush_i,
    tc_flush_d, tc_probe_i, tc_probe_d, mmu_reg_rd_i, mmu_reg_rd_d,
    mmu_reg_wr_i, mmu_reg_wr_d, tc_diag, cache_acc, line_flush_i,
    line_flush_d, block_copy, block_fill, passthru, rm_update_en,
    sysreg_acc, unasg_acc, mem_access};
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;
  asd_decoder u_asd_decoder (.core_clk(core_clk), .nrst(nrst),
    .req_valid(req_valid), .req_store(req_store), .req_priv(req_priv),
    .req_iside(req_iside), .req_size(req_size),
    .space_identifier(space_identifier), .virtual_addr(virtual_addr),
    .rsp_valid(rsp_valid), .access_error(access_error),
    .mmu_claim(mmu_claim), .tc_flush_i(tc_flush_i), .tc_flush_d(tc_flush_d),
    .tc_probe_i(tc_probe_i), .tc_probe_d(tc_probe_d),
    .tc_op_kind(tc_op_kind), .mmu_reg_rd_i(mmu_reg_rd_i),
    .mmu_reg_rd_d(mmu_reg_rd_d), .mmu_reg_wr_i(mmu_reg_wr_i),
    .mmu_reg_wr_d(mmu_reg_wr_d), .mmu_reg_sel(mmu_reg_sel),
    .tc_diag(tc_diag), .cache_acc(cache_acc), .line_flush_i(line_flush_i),
    .line_flush_d(line_flush_d), .line_flush_kind(line_flush_kind),
    .block_copy(block_copy), .block_fill(block_fill), .passthru(passthru),
    .rm_update_en(rm_update_en), .sysreg_acc(sysreg_acc),
    .unasg_acc(unasg_acc), .mem_access(mem_access), .mem_space(mem_space),
    .acc_store(acc_store), .physical_addr(physical_addr));
  asd_ipu_model u_asd_ipu_model (.core_clk(core_clk), .req_valid(req_valid),
    .req_store(req_store), .req_priv(req_priv), .req_iside(req_iside),
    .req_size(req_size), .space_identifier(space_identifier),
    .virtual_addr(virtual_addr));
  // Expected pulses; unassigned spaces have no responder in this build
  function automatic logic [26:0] exp_vec(input logic [7:0] s,
      input logic st, pv, isd, input logic [1:0] sz);
    logic md, er, lf;
    logic [26:0] v;
    md = s inside {[8'h08:8'h0b]};
    lf = s inside {[8'h10:8'h14], [8'h18:8'h1c]};
    er = s inside {8'h00, 8'h01, 8'h15, 8'h16, 8'h1d, 8'h1e} ||
         s >= 8'h30 || (!pv && !md) || (s == 8'h04 && sz != 2'h2);
    v = '0;
    v[26:24] = {1'b1, er, s inside {[8'h03:8'h0b], [8'h20:8'h2f]} && (pv || md)};
    if (!er) v[23:0] = {{2{s == 8'h03 && st}}, s == 8'h03 && !st && isd,
      s == 8'h03 && !st && !isd, s == 8'h04 && !st && isd,
      s == 8'h04 && !st && !isd, {2{s == 8'h04 && st}}, s == 8'h07,
      s == 8'h06, s == 8'h05, s == 8'h0f, s == 8'h0e, s == 8'h0d,
      s == 8'h0c, lf, s inside {[8'h10:8'h14]}, s == 8'h17, s == 8'h1f,
      s[7:4] == 4'h2, md, s == 8'h02, 1'b0, md};
    return v;
  endfunction
  task automatic check(input string what, input logic [35:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Judge the answer to the request taken at the last edge
  task automatic check_pend();
    logic [26:0] ev;
    ev = p_v ? exp_vec(p_sid, p_st, p_pv, p_isd, p_sz) : 27'h0;
    check("strobes", 36'(obs), 36'(ev));
    if (p_v) check("store flag", 36'(acc_store), 36'(p_st));
    if (p_v && !ev[25] && p_sid == 8'h03) check("op kind", 36'(tc_op_kind), 36'(p_adr[11:8]));
    if (p_v && p_pv && p_sid == 8'h04) check("reg sel", 36'(mmu_reg_sel), 36'(p_adr[11:8]));
    if (ev[8]) check("flush kind", 36'(line_flush_kind), 36'(p_sid[2:0]));
    if (ev[4]) check("pass addr", physical_addr, {p_sid[3:0], p_adr});
    if (ev[0]) check("mem addr", {mem_space, physical_addr[33:0]}, {p_sid[1:0], 2'h0, p_adr});
  endtask
  task automatic op(input logic [7:0] s, input logic [31:0] a,
                    input logic st, pv, isd, input logic [1:0] sz);
    u_asd_ipu_model.issue(s, a, st, pv, isd, sz);
    check_pend();
    {p_v, p_sid, p_adr, p_st, p_pv, p_isd, p_sz} = {1'b1, s, a, st, pv, isd, sz};
  endtask
  task automatic gap();
    u_asd_ipu_model.idle();
    check_pend();
    p_v = 1'b0;
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog well beyond the roughly 1400 cycles the tests need
  initial begin
    repeat (6000) @(posedge core_clk);
    err_total++;
    complete_run();
  end
  // Main sequence
  initial begin
    {err_total, compares, p_v, nrst} = '0;
    void'($urandom(45));
    repeat (8) @(posedge core_clk);
    #1 nrst = 1'b1;
    // Every identifier as load and store, back to back
    for (int i = 0; i < 512; i++) op(i[8:1], $urandom, i[0], 1'b1, 1'($urandom), 2'h2);
    gap();
    $display("test sweep done");
    // Flush and probe kinds, then register selects over all sizes
    for (int i = 0; i < 64; i++) op(8'h03, {20'($urandom), i[3:0], 8'($urandom)}, i[4], 1'b1, i[5], 2'h2);
    for (int i = 0; i < 128; i++) op(8'h04, {20'($urandom), i[3:0], 8'($urandom)}, i[6], 1'b1, 1'($urandom), i[5:4]);
    gap();
    $display("test mmu spaces done");
    // Unprivileged reach is refused outside the mandatory spaces
    for (int i = 0; i < 256; i++) op(i[7:0], $urandom, 1'($urandom), 1'b0, 1'($urandom), 2'h2);
    gap();
    $display("test unprivileged done");
    // Random mix with idle gaps
    for (int i = 0; i < 400; i++) begin
      if ($urandom_range(3) == 0) gap();
      else op(8'($urandom), $urandom, 1'($urandom), 1'($urandom_range(7) != 0), 1'($urandom), 2'($urandom));
    end
    // Reset while a pass-through answer is up clears every strobe and the address
    op(8'h2a, $urandom, 1'b1, 1'b1, 1'b0, 2'h2);
    gap();
    nrst = 1'b0;
    #1 check("reset strobes", 36'(obs), 36'h0);
    check("reset addr", physical_addr, 36'h0);
    @(posedge core_clk);
    #1 nrst = 1'b1;
    op(8'h24, 32'hffff_ffff, 1'b0, 1'b1, 1'b0, 2'h2);
    gap();
    $display("test random and reset done");
    complete_run();
  end
endmodule
`default_nettype wire

/* File: rtl/asd_addr.sv */
// Forms the pass-through physical address and the register sub-select
`include "asd_map.svh"
`default_nettype none
module asd_addr (
  asd_dec_if.adr_mp dec
);
  // -------------------------------------------------------------
  // Address forming
  // -------------------------------------------------------------
  // Upper nibble from the identifier, low word straight through
  assign dec.physical_addr = {dec.space_identifier[3:0],
                              dec.virtual_addr};
  // Bits 7:0 never reach the selector
  assign dec.sub_sel = dec.virtual_addr[`ASD_SUB_HI:`ASD_SUB_LO];
endmodule
`default_nettype wire

/* File: rtl/asd_classify.sv */
// Maps an 8-bit space identifier onto its space class
`include "asd_map.svh"
`default_nettype none
module asd_classify
  import asd_pkg::*;
(
  asd_dec_if.cls_mp dec
);
  logic [7:0] sid;
  assign sid = dec.space_identifier;

  // -------------------------------------------------------------
  // Full eight-bit decode
  // -------------------------------------------------------------
  // No bit is dropped, so no two identifiers alias
  always_comb begin
    dec.cls = ASD_RESERVED;
    if (sid >= `ASD_SID_PT_LO && sid <= `ASD_SID_PT_HI)
      dec.cls = ASD_PASS;
    else if (sid >= `ASD_SID_UNA_LO && sid <= `ASD_SID_UNA_HI)
      dec.cls = ASD_UNASSIGN;
    else if (sid >= `ASD_SID_FLB_LO && sid <= `ASD_SID_FLB_HI)
      dec.cls = ASD_FLUSH_B;
    else if (sid >= `ASD_SID_FLI_LO && sid <= `ASD_SID_FLI_HI)
      dec.cls = ASD_FLUSH_I;
    else if (sid == `ASD_SID_BCOPY)
      dec.cls = ASD_BCOPY;
    else if (sid == `ASD_SID_BFILL)
      dec.cls = ASD_BFILL;
    else if (sid == `ASD_SID_UNA1)
      dec.cls = ASD_UNASSIGN;
    else if (sid >= `ASD_SID_SYSREG && sid <= `ASD_SID_DC_DATA)
      // Low codes map straight onto the class codes
      dec.cls = asd_class_t'(sid[4:0]);
  end
endmodule
`default_nettype wire

/* File: rtl/asd_dec_if.sv */
// Carrier between the decoder top and its classify and address helpers
`default_nettype none
interface asd_dec_if;
  import asd_pkg::*;
  logic [7:0]  space_identifier;
  logic [31:0] virtual_addr;
  asd_class_t  cls;
  logic [35:0] physical_addr;
  logic [3:0]  sub_sel;
  modport top_mp (output space_identifier, output virtual_addr,
                  input cls, input physical_addr, input sub_sel);
  modport cls_mp (input space_identifier, output cls);
  modport adr_mp (input space_identifier, input virtual_addr,
                  output physical_addr, output sub_sel);
endinterface
`default_nettype wire

/* File: rtl/asd_decoder.sv */
// Alternate space decoder: steers each alternate access to its target
`include "asd_map.svh"
`default_nettype none
module asd_decoder
  import asd_pkg::*;
#(
  parameter bit SPLIT_TC  = 1'b1,
  parameter bit SYSREG_EN = 1'b1,
  parameter bit UNASG_EN  = 1'b0
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        req_valid,
  input  wire logic        req_store,
  input  wire logic        req_priv,
  input  wire logic        req_iside,
  input  wire logic [1:0]  req_size,
  input  wire logic [7:0]  space_identifier,
  input  wire logic [31:0] virtual_addr,
  output logic             rsp_valid,
  output logic             access_error,
  output logic             mmu_claim,
  output logic             tc_flush_i,
  output logic             tc_flush_d,
  output logic             tc_probe_i,
  output logic             tc_probe_d,
  output logic [3:0]       tc_op_kind,
  output logic             mmu_reg_rd_i,
  output logic             mmu_reg_rd_d,
  output logic             mmu_reg_wr_i,
  output logic             mmu_reg_wr_d,
  output logic [3:0]       mmu_reg_sel,
  output logic [2:0]       tc_diag,
  output logic [3:0]       cache_acc,
  output logic             line_flush_i,
  output logic             line_flush_d,
  output logic [2:0]       line_flush_kind,
  output logic             block_copy,
  output logic             block_fill,
  output logic             passthru,
  output logic             rm_update_en,
  output logic             sysreg_acc,
  output logic             unasg_acc,
  output logic             mem_access,
  output logic [1:0]       mem_space,
  output logic             acc_store,
  output logic [35:0]      physical_addr
);

  // -------------------------------------------------------------
  // Decode helpers
  // -------------------------------------------------------------
  asd_dec_if dec ();
  assign dec.space_identifier = space_identifier;
  assign dec.virtual_addr     = virtual_addr;

  asd_classify u_classify (
    .dec (dec.cls_mp)
  );

  asd_addr u_addr (
    .dec (dec.adr_mp)
  );

  // -------------------------------------------------------------
  // Next values
  // -------------------------------------------------------------
  logic        next_rsp_valid;
  logic        next_access_error;
  logic        next_mmu_claim;
  logic        next_tc_flush_i;
  logic        next_tc_flush_d;
  logic        next_tc_probe_i;
  logic        next_tc_probe_d;
  logic [3:0]  next_tc_op_kind;
  logic        next_mmu_reg_rd_i;
  logic        next_mmu_reg_rd_d;
  logic        next_mmu_reg_wr_i;
  logic        next_mmu_reg_wr_d;
  logic [3:0]  next_mmu_reg_sel;
  logic [2:0]  next_tc_diag;
  logic [3:0]  next_cache_acc;
  logic        next_line_flush_i;
  logic        next_line_flush_d;
  logic [2:0]  next_line_flush_kind;
  logic        next_block_copy;
  logic        next_block_fill;
  logic        next_passthru;
  logic        next_rm_update_en;
  logic        next_sysreg_acc;
  logic        next_unasg_acc;
  logic        next_mem_access;
  logic [1:0]  next_mem_space;
  logic        next_acc_store;
  logic [35:0] next_physical_addr;
  logic        mandatory;
  logic        side_i;
  logic        side_d;

  // Mandatory spaces are open to unprivileged code
  assign mandatory = (dec.cls == ASD_USER_I) || (dec.cls == ASD_SUP_I) ||
                     (dec.cls == ASD_USER_D) ||
                     (dec.cls == ASD_SUP_D);
  // Combined cache build answers probes and register reads on the data side
  assign side_i = SPLIT_TC && req_iside;
  assign side_d = !SPLIT_TC || !req_iside;

  // One request port for all MMU parts; routing decided here
  always_comb begin
    next_rsp_valid       = req_valid;
    next_access_error    = 1'b0;
    next_mmu_claim       = 1'b0;
    next_tc_flush_i      = 1'b0;
    next_tc_flush_d      = 1'b0;
    next_tc_probe_i      = 1'b0;
    next_tc_probe_d      = 1'b0;
    next_tc_op_kind      = tc_op_kind;
    next_mmu_reg_rd_i    = 1'b0;
    next_mmu_reg_rd_d    = 1'b0;
    next_mmu_reg_wr_i    = 1'b0;
    next_mmu_reg_wr_d    = 1'b0;
    next_mmu_reg_sel     = mmu_reg_sel;
    next_tc_diag         = 3'h0;
    next_cache_acc       = 4'h0;
    next_line_flush_i    = 1'b0;
    next_line_flush_d    = 1'b0;
    next_line_flush_kind = line_flush_kind;
    next_block_copy      = 1'b0;
    next_block_fill      = 1'b0;
    next_passthru        = 1'b0;
    next_rm_update_en    = 1'b0;
    next_sysreg_acc      = 1'b0;
    next_unasg_acc       = 1'b0;
    next_mem_access      = 1'b0;
    next_mem_space       = mem_space;
    next_acc_store       = acc_store;
    next_physical_addr   = physical_addr;
    if (req_valid) begin
      next_acc_store = req_store;
      // Identifier 3..0xB and the pass-through block belong to the MMU
      next_mmu_claim = (space_identifier >= `ASD_SID_TC_FP &&
                        space_identifier <= `ASD_SID_SUP_D) ||
                       (dec.cls == ASD_PASS);
      // Guard anyway: a stray unprivileged access must not act
      if (!req_priv && !mandatory) begin
        next_access_error = 1'b1;
        next_mmu_claim    = 1'b0;
      end else begin
        unique case (dec.cls)
          ASD_RESERVED: begin
            next_access_error = 1'b1;
          end
          ASD_UNASSIGN: begin
            // Only usable when an outside responder is fitted
            next_unasg_acc    = UNASG_EN;
            next_access_error = !UNASG_EN;
          end
          ASD_SYSREG: begin
            next_sysreg_acc   = SYSREG_EN;
            next_access_error = !SYSREG_EN;
          end
          ASD_TC_FP: begin
            next_tc_op_kind = dec.sub_sel;
            if (req_store) begin
              // Purge of every matching entry, so every part must see it
              next_tc_flush_d = 1'b1;
              next_tc_flush_i = SPLIT_TC;
            end else begin
              next_tc_probe_i = side_i;
              next_tc_probe_d = side_d;
            end
          end
          ASD_MMU_REG: begin
            next_mmu_reg_sel = dec.sub_sel;
            if (req_size != `ASD_SIZE_WORD) begin
              // Odd sizes do nothing to the registers
              next_access_error = 1'b1;
            end else if (req_store) begin
              // Duplicated registers stay in step
              next_mmu_reg_wr_d = 1'b1;
              next_mmu_reg_wr_i = SPLIT_TC;
            end else begin
              next_mmu_reg_rd_i = side_i;
              next_mmu_reg_rd_d = side_d;
            end
          end
          ASD_DIAG_I: begin
            next_tc_diag = 3'h1;
          end
          ASD_DIAG_D: begin
            next_tc_diag = 3'h2;
          end
          ASD_DIAG_IO: begin
            next_tc_diag = 3'h4;
          end
          ASD_USER_I, ASD_SUP_I, ASD_USER_D, ASD_SUP_D: begin
            // Translated access; space code bits 1:0 give user/sup, I/D
            next_mem_access    = 1'b1;
            next_mem_space     = space_identifier[1:0];
            next_rm_update_en  = 1'b1;
            next_physical_addr = {4'h0, virtual_addr};
          end
          ASD_IC_TAG: begin
            next_cache_acc = 4'h1;
          end
          ASD_IC_DATA: begin
            next_cache_acc = 4'h2;
          end
          ASD_DC_TAG: begin
            next_cache_acc = 4'h4;
          end
          ASD_DC_DATA: begin
            next_cache_acc = 4'h8;
          end
          ASD_FLUSH_B: begin
            next_line_flush_kind = space_identifier[2:0];
            next_line_flush_i    = SPLIT_TC;
            next_line_flush_d    = 1'b1;
          end
          ASD_FLUSH_I: begin
            next_line_flush_kind = space_identifier[2:0];
            next_line_flush_i    = 1'b1;
          end
          ASD_BCOPY: begin
            next_block_copy = 1'b1;
          end
          ASD_BFILL: begin
            next_block_fill = 1'b1;
          end
          ASD_PASS: begin
            next_passthru      = 1'b1;
            next_physical_addr = dec.physical_addr;
            // No page table entry is touched on this path
            next_rm_update_en  = 1'b0;
          end
          default: begin
            next_access_error = 1'b1;
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // Output registers
  // -------------------------------------------------------------
  // Strobes last one cycle; selects and address hold until a request that drives them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid       <= 1'b0;
      access_error    <= 1'b0;
      mmu_claim       <= 1'b0;
      tc_flush_i      <= 1'b0;
      tc_flush_d      <= 1'b0;
      tc_probe_i      <= 1'b0;
      tc_probe_d      <= 1'b0;
      tc_op_kind      <= 4'h0;
      mmu_reg_rd_i    <= 1'b0;
      mmu_reg_rd_d    <= 1'b0;
      mmu_reg_wr_i    <= 1'b0;
      mmu_reg_wr_d    <= 1'b0;
      mmu_reg_sel     <= 4'h0;
      tc_diag         <= 3'h0;
      cache_acc       <= 4'h0;
      line_flush_i    <= 1'b0;
      line_flush_d    <= 1'b0;
      line_flush_kind <= 3'h0;
      block_copy      <= 1'b0;
      block_fill      <= 1'b0;
      passthru        <= 1'b0;
      rm_update_en    <= 1'b0;
      sysreg_acc      <= 1'b0;
      unasg_acc       <= 1'b0;
      mem_access      <= 1'b0;
      mem_space       <= 2'h0;
      acc_store       <= 1'b0;
      physical_addr   <= 36'h0;
    end else begin
      rsp_valid       <= next_rsp_valid;
      access_error    <= next_access_error;
      mmu_claim       <= next_mmu_claim;
      tc_flush_i      <= next_tc_flush_i;
      tc_flush_d      <= next_tc_flush_d;
      tc_probe_i      <= next_tc_probe_i;
      tc_probe_d      <= next_tc_probe_d;
      tc_op_kind      <= next_tc_op_kind;
      mmu_reg_rd_i    <= next_mmu_reg_rd_i;
      mmu_reg_rd_d    <= next_mmu_reg_rd_d;
      mmu_reg_wr_i    <= next_mmu_reg_wr_i;
      mmu_reg_wr_d    <= next_mmu_reg_wr_d;
      mmu_reg_sel     <= next_mmu_reg_sel;
      tc_diag         <= next_tc_diag;
      cache_acc       <= next_cache_acc;
      line_flush_i    <= next_line_flush_i;
      line_flush_d    <= next_line_flush_d;
      line_flush_kind <= next_line_flush_kind;
      block_copy      <= next_block_copy;
      block_fill      <= next_block_fill;
      passthru        <= next_passthru;
      rm_update_en    <= next_rm_update_en;
      sysreg_acc      <= next_sysreg_acc;
      unasg_acc       <= next_unasg_acc;
      mem_access      <= next_mem_access;
      mem_space       <= next_mem_space;
      acc_store       <= next_acc_store;
      physical_addr   <= next_physical_addr;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/asd_map.svh */
// Space identifier codes and field positions for the alternate space decoder
// Summary of operation
// - Decode all eight identifier bits; all 256 spaces stay distinct.
// - Spaces 8, 9, 0xA, 0xB are user/supervisor instruction and data.
// - MMU claims spaces 3 to 0xB and 0x20 to 0x2F only.
// - Space 3 flush/probe kind comes from virtual address bits 11:8.
// - Space 3: one store is a flush, one load is a probe.
// - A space 3 flush purges every matching translation cache entry.
// - Split caches: applicable one answers probes, both perform flushes.
// - Space 4 accesses one MMU register chosen by virtual address 11:8.
// - Split caches: the applicable one reads registers, both take writes.
// - Space 4 byte, halfword or doubleword access is flagged as error.
// - Space 4 register select ignores virtual address bits 7:0.
// - Spaces 5, 6, 7: diagnostics of instruction, data, I/O caches.
// - 0xC/0xD instruction cache tag/data; 0xE/0xF data cache tag/data.
// - Spaces 0x10-0x14 flush a line in both caches, by match kind.
// - Spaces 0x18-0x1C flush an instruction cache line only.
// - Space 0x17 is block copy, space 0x1F is block fill.
// - Spaces 0x20-0x2F bypass translation to a physical address.
// - 0, 0x15, 0x16, 0x1D, 0x1E, 0x80+ reserved; 1, 0x30-0x7F free.
// - Space 2 reaches implementation specific system status registers.
// - Split MMU parts still present one interface to the processor.
// - Pass-through: physical 35:32 from identifier 3:0, 31:0 from address.
// - Pass-through leaves referenced and modified bits unchanged.
`ifndef ASD_MAP_SVH
`define ASD_MAP_SVH
`define ASD_SID_UNA1      8'h01
`define ASD_SID_SYSREG    8'h02
`define ASD_SID_TC_FP     8'h03
`define ASD_SID_MMU_REG   8'h04
`define ASD_SID_DIAG_I    8'h05
`define ASD_SID_DIAG_D    8'h06
`define ASD_SID_DIAG_IO   8'h07
`define ASD_SID_USER_I    8'h08
`define ASD_SID_SUP_I     8'h09
`define ASD_SID_USER_D    8'h0a
`define ASD_SID_SUP_D     8'h0b
`define ASD_SID_IC_TAG    8'h0c
`define ASD_SID_IC_DATA   8'h0d
`define ASD_SID_DC_TAG    8'h0e
`define ASD_SID_DC_DATA   8'h0f
`define ASD_SID_FLB_LO    8'h10
`define ASD_SID_FLB_HI    8'h14
`define ASD_SID_BCOPY     8'h17
`define ASD_SID_FLI_LO    8'h18
`define ASD_SID_FLI_HI    8'h1c
`define ASD_SID_BFILL     8'h1f
`define ASD_SID_PT_LO     8'h20
`define ASD_SID_PT_HI     8'h2f
`define ASD_SID_UNA_LO    8'h30
`define ASD_SID_UNA_HI    8'h7f
`define ASD_SUB_HI        11
`define ASD_SUB_LO        8
`define ASD_SIZE_WORD     2'h2
`endif

/* File: rtl/asd_pkg.sv */
// Types shared by the alternate space decoder modules
`default_nettype none
package asd_pkg;
  typedef enum logic [4:0] {
    ASD_RESERVED = 5'h00,
    ASD_UNASSIGN = 5'h01,
    ASD_SYSREG   = 5'h02,
    ASD_TC_FP    = 5'h03,
    ASD_MMU_REG  = 5'h04,
    ASD_DIAG_I   = 5'h05,
    ASD_DIAG_D   = 5'h06,
    ASD_DIAG_IO  = 5'h07,
    ASD_USER_I   = 5'h08,
    ASD_SUP_I    = 5'h09,
    ASD_USER_D   = 5'h0a,
    ASD_SUP_D    = 5'h0b,
    ASD_IC_TAG   = 5'h0c,
    ASD_IC_DATA  = 5'h0d,
    ASD_DC_TAG   = 5'h0e,
    ASD_DC_DATA  = 5'h0f,
    ASD_FLUSH_B  = 5'h10,
    ASD_FLUSH_I  = 5'h11,
    ASD_BCOPY    = 5'h12,
    ASD_BFILL    = 5'h13,
    ASD_PASS     = 5'h14
  } asd_class_t;
endpackage
`default_nettype wire
